// *** cdr_consts.vh ***
// constants for the codec direct host register bank
`ifndef CDR_CONSTS_VH
`define CDR_CONSTS_VH

// ------------------------------------------------------------------
// direct register offsets
// ------------------------------------------------------------------
`define CDR_OFS_INDEX       2'h0
`define CDR_OFS_IDATA       2'h1
`define CDR_OFS_STATUS      2'h2
`define CDR_OFS_SDATA       2'h3

// ------------------------------------------------------------------
// index pointer fields and values
// ------------------------------------------------------------------
`define CDR_IDX_INIT_BIT    7
`define CDR_IDX_MCE_BIT     6
`define CDR_IDX_TRD_BIT     5
`define CDR_IDX_TOP_BIT     4
`define CDR_IDX_RESET       8'h40
`define CDR_BUSY_READ       8'h80
`define CDR_PWR_DOWN        2'h1

// ------------------------------------------------------------------
// status fields
// ------------------------------------------------------------------
`define CDR_ST_INT          0
`define CDR_ST_PLAYBACK_READY         1
`define CDR_ST_PLR          2
`define CDR_ST_PUL          3
`define CDR_ST_SER          4
`define CDR_ST_CAPTURE_READY         5
`define CDR_ST_CLR          6
`define CDR_ST_CUL          7

// ------------------------------------------------------------------
// indirect register indices and fields
// ------------------------------------------------------------------
`define CDR_IR_PLAY_FMT     5'h08
`define CDR_IR_IFACE_CFG    5'h09
`define CDR_IR_PIN_CTRL     5'h0A
`define CDR_IR_ALT_STATUS   5'h18
`define CDR_IR_CAP_FMT      5'h1C
`define CDR_IR_EXT_FIRST    5'h10
`define CDR_CFG_PEN_BIT     0
`define CDR_CFG_CEN_BIT     1
`define CDR_CFG_LIVE_MASK   8'h03
`define CDR_PIN_IEN_BIT     1
`define CDR_ALT_PUR_BIT     4
`define CDR_ALT_COR_BIT     5
`define CDR_FMT_STEREO_BIT  4
`define CDR_FMT_CL_BIT      5
`define CDR_FMT_F0_BIT      6
`define CDR_FMT_F1_BIT      7
`define CDR_IREG_RESET      8'h00

`endif

// *** cdr_regs.v ***
// direct host register bank of the codec section
`timescale 1ns/1ns
`default_nettype none
`include "cdr_consts.vh"

module cdr_regs (
    input  wire        clock_in,
    input  wire        rstn_in,
    input  wire [1:0]  addr_in,
    input  wire        wr_in,
    input  wire        rd_in,
    input  wire [7:0]  wdata_in,
    input  wire        init_busy_in,
    input  wire [1:0]  power_state_in,
    input  wire        ext_mode_in,
    input  wire        irq_event_in,
    input  wire        play_fifo_ready_in,
    input  wire        play_tick_in,
    input  wire        cap_valid_in,
    input  wire [31:0] cap_sample_in,
    input  wire        cap_tick_in,
    output reg  [7:0]  rdata_out,
    output reg         irq_out,
    output reg         play_drq_allow_out,
    output reg         cap_drq_allow_out,
    output reg         play_valid_out,
    output reg  [31:0] play_sample_out,
    output reg  [2:0]  play_bytes_out,
    output reg         cap_ready_out
);

// ------------------------------------------------------------------
// format helpers
// ------------------------------------------------------------------
function [2:0] nbytes;
    input [7:0] fmt;
    reg         wide;
    begin
        wide = fmt[`CDR_FMT_F0_BIT] & ~fmt[`CDR_FMT_CL_BIT];
        if (fmt[`CDR_FMT_F1_BIT] & fmt[`CDR_FMT_CL_BIT] &
            ~fmt[`CDR_FMT_F0_BIT]) begin
            nbytes = 3'h4;
        end else if (wide) begin
            nbytes = fmt[`CDR_FMT_STEREO_BIT] ? 3'h4 : 3'h2;
        end else begin
            nbytes = fmt[`CDR_FMT_STEREO_BIT] ? 3'h2 : 3'h1;
        end
    end
endfunction

// returns {side, half} for byte k of a sample
function [1:0] side_half;
    input [7:0] fmt;
    input [2:0] k;
    reg         adpcm;
    reg         wide;
    reg         big;
    begin
        adpcm = fmt[`CDR_FMT_F1_BIT] & fmt[`CDR_FMT_CL_BIT] &
                ~fmt[`CDR_FMT_F0_BIT];
        wide  = fmt[`CDR_FMT_F0_BIT] & ~fmt[`CDR_FMT_CL_BIT];
        big   = fmt[`CDR_FMT_F1_BIT];
        if (adpcm) begin
            side_half = {(k < 3'h2), k[0]};
        end else if (wide) begin
            side_half = {(~fmt[`CDR_FMT_STEREO_BIT] | (k < 3'h2)),
                         (big ? ~k[0] : k[0])};
        end else begin
            side_half = {(~fmt[`CDR_FMT_STEREO_BIT] | (k == 3'h0)), 1'b1};
        end
    end
endfunction

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
wire [7:0]  idx_rst   = `CDR_IDX_RESET;

// ------------------------------------------------------------------
// state
// ------------------------------------------------------------------
reg  [7:0]  ireg_r [0:31];
reg  [4:0]  idx_r;
reg         mce_r;
reg         trd_r;
reg         int_r;
reg         ser_r;
reg  [2:0]  pcnt_r;
reg  [31:0] pdata_r;
reg         psent_r;
reg  [2:0]  ccnt_r;
reg  [31:0] cdata_r;
reg         capture_ready_r;
reg         cseen_r;
reg  [2:0]  cbytes_r;
integer     i;

wire        busy      = init_busy_in | (power_state_in == `CDR_PWR_DOWN);
wire        wr_idx    = wr_in & (addr_in == `CDR_OFS_INDEX);
wire        wr_data   = wr_in & (addr_in == `CDR_OFS_IDATA);
wire        wr_stat   = wr_in & (addr_in == `CDR_OFS_STATUS);
wire        wr_port   = wr_in & (addr_in == `CDR_OFS_SDATA);
wire        rd_stat   = rd_in & (addr_in == `CDR_OFS_STATUS);
wire        rd_port   = rd_in & (addr_in == `CDR_OFS_SDATA);
wire [7:0]  pfmt      = ireg_r[`CDR_IR_PLAY_FMT];
wire [7:0]  cfmt      = ext_mode_in ? ireg_r[`CDR_IR_CAP_FMT] : pfmt;
wire [7:0]  cfg       = ireg_r[`CDR_IR_IFACE_CFG];
wire        playback_enable       = cfg[`CDR_CFG_PEN_BIT];
wire        capture_enable       = cfg[`CDR_CFG_CEN_BIT];
wire [2:0]  pneed     = nbytes(pfmt);
wire        pfull     = (pcnt_r == pneed);
wire [2:0]  pk        = pfull ? pneed - 3'h1 : pcnt_r;
wire [1:0]  pflags    = side_half(pfmt, pk);
wire [1:0]  cflags    = side_half(cfmt, ccnt_r);
wire        idx_hid   = ~ext_mode_in & (idx_r >= `CDR_IR_EXT_FIRST);
wire        cap_load  = cap_valid_in & cap_ready_out;
wire        play_send = rd_stat & pfull & play_fifo_ready_in;
wire        cap_last  = (ccnt_r == cbytes_r - 3'h1);
wire [7:0]  status    = {cflags[0], cflags[1], capture_ready_r, ser_r,
                         pflags[0], pflags[1], ~pfull, int_r};
wire        p_under   = play_tick_in & playback_enable & ~psent_r;
wire        c_over    = cap_tick_in & capture_enable & capture_ready_r;

// ------------------------------------------------------------------
// host read path
// ------------------------------------------------------------------
always @(posedge clock_in) begin
    if (!rstn_in) begin
        rdata_out <= 8'h00;
    end else if (rd_in) begin
        case (addr_in)
            `CDR_OFS_INDEX: begin
                if (busy) begin
                    rdata_out <= `CDR_BUSY_READ;
                end else begin
                    rdata_out <= {1'b0, mce_r, trd_r, idx_r};
                end
            end
            `CDR_OFS_IDATA: begin
                if (busy) begin
                    rdata_out <= `CDR_BUSY_READ;
                end else if (idx_hid) begin
                    rdata_out <= 8'h00;
                end else begin
                    rdata_out <= ireg_r[idx_r];
                end
            end
            `CDR_OFS_STATUS: begin
                rdata_out <= status;
            end
            default: begin
                if (busy) begin
                    rdata_out <= `CDR_BUSY_READ;
                end else begin
                    rdata_out <= cdata_r[{ccnt_r[1:0], 3'h0} +: 8];
                end
            end
        endcase
    end
end

// ------------------------------------------------------------------
// index pointer and indirect registers
// ------------------------------------------------------------------
always @(posedge clock_in) begin
    if (!rstn_in) begin
        idx_r <= idx_rst[4:0];
        mce_r <= idx_rst[`CDR_IDX_MCE_BIT];
        trd_r <= idx_rst[`CDR_IDX_TRD_BIT];
        for (i = 0; i < 32; i = i + 1) begin
            ireg_r[i] <= `CDR_IREG_RESET;
        end
    end else begin
        if (wr_idx & ~busy) begin
            idx_r <= {wdata_in[`CDR_IDX_TOP_BIT] & ext_mode_in,
                      wdata_in[3:0]};
            mce_r <= wdata_in[`CDR_IDX_MCE_BIT];
            trd_r <= wdata_in[`CDR_IDX_TRD_BIT];
        end
        if (wr_data & ~busy & ~idx_hid) begin
            if (idx_r == `CDR_IR_PLAY_FMT || idx_r == `CDR_IR_CAP_FMT) begin
                if (mce_r) begin
                    ireg_r[idx_r] <= wdata_in;
                end
            end else if (idx_r == `CDR_IR_IFACE_CFG) begin
                if (mce_r) begin
                    ireg_r[idx_r] <= wdata_in;
                end else begin
                    ireg_r[idx_r] <= (ireg_r[idx_r] & ~`CDR_CFG_LIVE_MASK)
                                   | (wdata_in & `CDR_CFG_LIVE_MASK);
                end
            end else if (idx_r == `CDR_IR_ALT_STATUS) begin
                ireg_r[idx_r] <= wdata_in & ireg_r[idx_r];
            end else begin
                ireg_r[idx_r] <= wdata_in;
            end
        end
        if (p_under) begin
            ireg_r[`CDR_IR_ALT_STATUS][`CDR_ALT_PUR_BIT] <= 1'b1;
        end
        if (c_over) begin
            ireg_r[`CDR_IR_ALT_STATUS][`CDR_ALT_COR_BIT] <= 1'b1;
        end
    end
end

// ------------------------------------------------------------------
// interrupt, sample error and request gating
// ------------------------------------------------------------------
always @(posedge clock_in) begin
    if (!rstn_in) begin
        int_r              <= 1'b0;
        ser_r              <= 1'b0;
        irq_out            <= 1'b0;
        play_drq_allow_out <= 1'b0;
        cap_drq_allow_out  <= 1'b0;
    end else begin
        if (irq_event_in) begin
            int_r <= 1'b1;
        end else if (wr_stat) begin
            int_r <= 1'b0;
        end
        if (p_under | c_over) begin
            ser_r <= 1'b1;
        end else if (wr_stat) begin
            ser_r <= 1'b0;
        end
        irq_out <= int_r &
                   ireg_r[`CDR_IR_PIN_CTRL][`CDR_PIN_IEN_BIT];
        play_drq_allow_out <= playback_enable & ~(trd_r & int_r);
        cap_drq_allow_out  <= capture_enable & ~(trd_r & int_r);
    end
end

// ------------------------------------------------------------------
// playback byte tracker
// ------------------------------------------------------------------
always @(posedge clock_in) begin
    if (!rstn_in) begin
        pcnt_r          <= 3'h0;
        pdata_r         <= 32'h0000_0000;
        psent_r         <= 1'b0;
        play_valid_out  <= 1'b0;
        play_sample_out <= 32'h0000_0000;
        play_bytes_out  <= 3'h0;
    end else begin
        play_valid_out <= play_send;
        if (play_send) begin
            play_sample_out <= pdata_r;
            play_bytes_out  <= pneed;
            pcnt_r          <= 3'h0;
            psent_r         <= 1'b1;
        end else if (wr_port & ~busy & ~pfull) begin
            pdata_r[{pcnt_r[1:0], 3'h0} +: 8] <= wdata_in;
            pcnt_r <= pcnt_r + 3'h1;
        end
        if (play_tick_in & ~play_send) begin
            psent_r <= 1'b0;
        end
    end
end

// ------------------------------------------------------------------
// capture next-state terms
// ------------------------------------------------------------------
reg         capture_ready_nxt;
reg         cseen_nxt;

always @* begin
    capture_ready_nxt  = capture_ready_r;
    cseen_nxt = cseen_r | rd_stat;
    if (cap_load) begin
        capture_ready_nxt  = 1'b1;
        cseen_nxt = 1'b0;
    end else if (rd_port & ~busy & capture_ready_r & cap_last) begin
        capture_ready_nxt  = 1'b0;
    end
end

// ------------------------------------------------------------------
// capture byte tracker
// ------------------------------------------------------------------
always @(posedge clock_in) begin
    if (!rstn_in) begin
        ccnt_r        <= 3'h0;
        cdata_r       <= 32'h0000_0000;
        capture_ready_r        <= 1'b0;
        cseen_r       <= 1'b0;
        cbytes_r      <= 3'h1;
        cap_ready_out <= 1'b0;
    end else begin
        if (cap_load) begin
            cdata_r  <= cap_sample_in;
            ccnt_r   <= 3'h0;
            cbytes_r <= nbytes(cfmt);
            capture_ready_r   <= 1'b1;
            cseen_r  <= 1'b0;
        end else begin
            if (rd_port & ~busy & capture_ready_r) begin
                if (cap_last) begin
                    capture_ready_r <= 1'b0;
                end else begin
                    ccnt_r <= ccnt_r + 3'h1;
                end
            end
            if (rd_stat) begin
                cseen_r <= 1'b1;
            end
        end
        cap_ready_out <= ~capture_ready_nxt & cseen_nxt;
    end
end

endmodule // cdr_regs
`default_nettype wire

// *** cdr_regs_props.sv ***
// assertion checker for the codec direct host register bank
`timescale 1ns/1ns
`default_nettype none
module cdr_regs_props (
    input wire logic       clock_in,
    input wire logic       rstn_in,
    input wire logic [1:0] addr_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic       init_busy_in,
    input wire logic [1:0] power_state_in,
    input wire logic       irq_event_in,
    input wire logic       play_fifo_ready_in,
    input wire logic [7:0] rdata_out,
    input wire logic       irq_out,
    input wire logic       play_valid_out,
    input wire logic [2:0] play_bytes_out,
    input wire logic       cap_ready_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // ------------------------------------------------------------
    // assertions and cover points
    // ------------------------------------------------------------
    a_busy_read: assert property (
        rd_in && addr_in != 2'h2 && (init_busy_in || power_state_in == 2'h1)
        |=> rdata_out == 8'h80) else $error("busy read not 80");
    a_irq_pin_clear: assert property (
        (wr_in && addr_in == 2'h2 && !irq_event_in) ##1 !irq_event_in
        |=> !irq_out) else $error("irq pin stays after ack");
    a_int_bit_clear: assert property (
        (wr_in && addr_in == 2'h2 && !irq_event_in) ##1 !irq_event_in
        ##1 (rd_in && addr_in == 2'h2) |=> !rdata_out[0])
        else $error("int bit stays after ack");
    a_send_pulse: assert property (
        play_valid_out |=> !play_valid_out) else $error("send not a pulse");
    a_send_cause: assert property (
        play_valid_out |-> $past(rd_in && addr_in == 2'h2 && play_fifo_ready_in))
        else $error("send without status read");
    a_send_count: assert property (
        play_valid_out |-> play_bytes_out == 3'h1 || play_bytes_out == 3'h2
        || play_bytes_out == 3'h4) else $error("bad byte count");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn_in |=> rdata_out == 8'h00 && !irq_out && !play_valid_out
        && !cap_ready_out) else $error("outputs not clear in reset");
    a_read_holds: assert property (
        !rd_in |=> $stable(rdata_out)) else $error("read data moved");
    c_send: cover property (play_valid_out);
    c_irq: cover property (irq_out);
    c_cap: cover property (cap_ready_out);
endmodule // cdr_regs_props

bind cdr_regs cdr_regs_props cdr_regs_props_inst (.clock_in, .rstn_in,
    .addr_in, .wr_in, .rd_in, .init_busy_in, .power_state_in, .irq_event_in,
    .play_fifo_ready_in, .rdata_out, .irq_out, .play_valid_out,
    .play_bytes_out, .cap_ready_out);
`default_nettype wire

// *** cdr_host_model.sv ***
// host bus model doing byte reads and writes to the register bank
`timescale 1ns/1ns
`default_nettype none
module cdr_host_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    output var  logic [1:0] addr_out,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic [7:0] wdata_out
);
    initial begin
        addr_out = 2'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // byte write; a status write acknowledges
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clock_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // byte read, data taken after the register updates
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clock_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask
endmodule // cdr_host_model
`default_nettype wire

// *** tb_cdr_regs.sv ***
// self-checking testbench of the codec direct host register bank
`timescale 1ns/1ns
`default_nettype none
module tb_cdr_regs;
    logic        clock_in, rstn_in, wr_in, rd_in, init_busy_in, ext_mode_in;
    logic        irq_event_in, play_fifo_ready_in, play_tick_in, cap_valid_in;
    logic        cap_tick_in, irq_out, play_drq_allow_out, cap_drq_allow_out;
    logic        play_valid_out, cap_ready_out;
    logic [1:0]  addr_in, power_state_in;
    logic [7:0]  wdata_in, rdata_out, v;
    logic [31:0] cap_sample_in, play_sample_out;
    logic [2:0]  play_bytes_out;
    int          num_errors, n_compared;

    cdr_regs cdr_regs_inst (.clock_in, .rstn_in, .addr_in, .wr_in, .rd_in,
        .wdata_in, .init_busy_in, .power_state_in, .ext_mode_in,
        .irq_event_in, .play_fifo_ready_in, .play_tick_in, .cap_valid_in,
        .cap_sample_in, .cap_tick_in, .rdata_out, .irq_out,
        .play_drq_allow_out, .cap_drq_allow_out, .play_valid_out,
        .play_sample_out, .play_bytes_out, .cap_ready_out);
    cdr_host_model cdr_host_model_inst (.clock_in, .rdata_in(rdata_out),
        .addr_out(addr_in), .wr_out(wr_in), .rd_out(rd_in),
        .wdata_out(wdata_in));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task w(input logic [1:0] a, input logic [7:0] d);
        cdr_host_model_inst.wr_reg(a, d);
    endtask
    task r(input logic [1:0] a, input logic [7:0] e, input string nm);
        cdr_host_model_inst.rd_reg(a, v);
        chk(nm, e, v);
    endtask
    task rs;
        cdr_host_model_inst.rd_reg(2'h2, v);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task cap_offer(input logic [31:0] s);
        for (int i = 0; i < 10 && cap_ready_out !== 1'b1; i++)
            @(negedge clock_in);
        @(posedge clock_in) cap_valid_in <= 1'b1;
        cap_sample_in <= s;
        @(posedge clock_in) cap_valid_in <= 1'b0;
        idle(2);
    endtask
    task wrap_up;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_index;
        r(2'h0, 8'h40, "index reset");
        w(2'h0, 8'h0A);
        r(2'h0, 8'h0A, "index");
        w(2'h0, 8'h1F);
        r(2'h0, 8'h0F, "index top basic");
    endtask
    task t_busy;
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_in) init_busy_in <= (k == 0);
            power_state_in <= (k == 0) ? 2'h0 : 2'h1;
            w(2'h0, 8'h03);
            r(2'h0, 8'h80, "busy index");
            r(2'h1, 8'h80, "busy window");
            r(2'h3, 8'h80, "busy port");
        end
        @(posedge clock_in) power_state_in <= 2'h0;
        r(2'h0, 8'h0F, "index kept");
    endtask
    task t_irq;
        w(2'h0, 8'h0A);
        w(2'h1, 8'h02);
        r(2'h1, 8'h02, "pin ctrl");
        @(posedge clock_in) irq_event_in <= 1'b1;
        @(posedge clock_in) irq_event_in <= 1'b0;
        rs();
        chk("int bit", 1, v[0]);
        chk("irq pin", 1, irq_out);
        w(2'h1, 8'h00);
        idle(2);
        chk("irq masked", 0, irq_out);
        w(2'h1, 8'h02);
        w(2'h2, 8'hFF);
        rs();
        chk("int acked", 0, v[0]);
    endtask
    task t_play;
        w(2'h0, 8'h48);
        w(2'h1, 8'h40);
        w(2'h0, 8'h08);
        w(2'h1, 8'hC0);
        r(2'h1, 8'h40, "format lock");
        rs();
        chk("playback_ready", 3'b011, v[3:1]);
        w(2'h3, 8'h34);
        rs();
        chk("upper next", 1, v[3]);
        w(2'h3, 8'h12);
        rs();
        chk("playback_ready full", 0, v[1]);
        w(2'h3, 8'h99);
        @(posedge clock_in) play_fifo_ready_in <= 1'b1;
        rs();
        chk("sent", 1, play_valid_out);
        chk("sample", 16'h1234, play_sample_out[15:0]);
        chk("count", 3'h2, play_bytes_out);
        rs();
        chk("playback_ready again", 1, v[1]);
    endtask
    task t_cap;
        chk("cap ready", 1, cap_ready_out);
        cap_offer(32'hAABBCCDD);
        chk("cap taken", 0, cap_ready_out);
        rs();
        chk("cap flags", 3'b011, v[7:5]);
        r(2'h3, 8'hDD, "cap byte0");
        rs();
        chk("cap upper", 1, v[7]);
        r(2'h3, 8'hCC, "cap byte1");
        rs();
        chk("cap stale", 0, v[5]);
        r(2'h3, 8'hCC, "cap last");
        cap_offer(32'h11223344);
        r(2'h3, 8'h44, "cap new");
    endtask
    task t_drq;
        w(2'h0, 8'h09);
        w(2'h1, 8'h01);
        idle(2);
        chk("play drq", 1, play_drq_allow_out);
        chk("cap drq", 0, cap_drq_allow_out);
        w(2'h0, 8'h29);
        @(posedge clock_in) irq_event_in <= 1'b1;
        @(posedge clock_in) irq_event_in <= 1'b0;
        idle(2);
        chk("drq held", 0, play_drq_allow_out);
        w(2'h2, 8'h00);
        idle(2);
        chk("drq free", 1, play_drq_allow_out);
        repeat (2) begin
            @(posedge clock_in) play_tick_in <= 1'b1;
            @(posedge clock_in) play_tick_in <= 1'b0;
        end
        rs();
        chk("underrun", 1, v[4]);
        @(posedge clock_in) ext_mode_in <= 1'b1;
        w(2'h0, 8'h18);
        cdr_host_model_inst.rd_reg(2'h1, v);
        chk("alt source", 1, v[4]);
        w(2'h1, 8'h00);
        w(2'h0, 8'h09);
        w(2'h1, 8'h03);
        idle(2);
        chk("cap drq on", 1, cap_drq_allow_out);
        @(posedge clock_in) cap_tick_in <= 1'b1;
        @(posedge clock_in) cap_tick_in <= 1'b0;
        w(2'h0, 8'h18);
        cdr_host_model_inst.rd_reg(2'h1, v);
        chk("alt overrun", 1, v[5]);
        chk("alt cleared", 0, v[4]);
        @(posedge clock_in) ext_mode_in <= 1'b0;
        r(2'h1, 8'h00, "basic hides");
    endtask
    // ------------------------------------------------------------
    // clock, reset, sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        {rstn_in, init_busy_in, ext_mode_in, irq_event_in} = 4'h0;
        {play_fifo_ready_in, play_tick_in, cap_valid_in, cap_tick_in} = 4'h0;
        power_state_in = 2'h0;
        cap_sample_in = 32'h0;
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_index();
        t_busy();
        t_irq();
        t_play();
        t_cap();
        t_drq();
        wrap_up();
    end
endmodule // tb_cdr_regs
`default_nettype wire
